// file: hwc_hub_model.sv
// platform hub model: releases the wake pin, takes the source message, acknowledges it
`timescale 1ns/1ps
module hwc_hub_model #(
  parameter int DLY = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wake_request_n_i,
  input wire logic src_msg_valid_i,
  input wire logic [15:0] src_msg_i,
  output logic release_msg_o,
  output logic hub_ack_o,
  output logic src_msg_ready_o,
  output logic [15:0] last_msg_o
);
  logic [1:0] st;
  logic [7:0] cnt;
  // ==========================================================
  // handshake sequencer
  // release then acknowledge
  always_ff @(posedge clk_i)
  begin
    release_msg_o <= 1'b0;
    hub_ack_o <= 1'b0;
    if (rst_i)
    begin
      st <= 2'h0;
      cnt <= 8'h00;
      src_msg_ready_o <= 1'b0;
      last_msg_o <= 16'h0000;
    end
    else if (st == 2'h0)
    begin
      cnt <= wake_request_n_i ? 8'h00 : cnt + 8'h01;
      if (!wake_request_n_i && cnt == 8'(DLY))
      begin
        release_msg_o <= 1'b1;
        st <= 2'h1;
        cnt <= 8'h00;
      end
    end
    else if (st == 2'h1)
    begin
      cnt <= cnt + 8'h01;
      src_msg_ready_o <= (cnt >= 8'(DLY));
      if (src_msg_valid_i && src_msg_ready_o)
      begin
        last_msg_o <= src_msg_i;
        src_msg_ready_o <= 1'b0;
        st <= 2'h2;
        cnt <= 8'h00;
      end
    end
    else
    begin
      cnt <= cnt + 8'h01;
      if (cnt == 8'(DLY))
      begin
        hub_ack_o <= 1'b1;
        st <= 2'h0;
        cnt <= 8'h00;
      end
    end
  end
endmodule

// file: hwc_pkg.sv
// package: register map, field positions, timing and carrier types for host wake control
package hwc_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [11:0] OFF_PORT_CFG = 12'h000;
  localparam logic [11:0] OFF_RX_CTRL = 12'h004;
  localparam logic [11:0] OFF_WAKE_CTRL = 12'h008;
  localparam logic [11:0] OFF_WAKE_FILT = 12'h00c;
  localparam logic [11:0] OFF_WAKE_STAT = 12'h010;
  localparam logic [11:0] OFF_APM_CFG = 12'h014;
  localparam logic [11:0] OFF_STA_W0 = 12'h018;
  localparam logic [11:0] OFF_STA_W1 = 12'h01c;
  localparam logic [11:0] OFF_STA_W2 = 12'h020;
  localparam logic [11:0] OFF_STA_LOW = 12'h024;
  localparam logic [11:0] OFF_STA_HIGH = 12'h028;
  localparam logic [11:0] OFF_CAP_CTRL = 12'h02c;
  localparam logic [11:0] OFF_CAP_LEN = 12'h030;
  localparam logic [11:0] OFF_CAP_CLR = 12'h034;
  localparam logic [11:0] OFF_FLEX_VAL = 12'h100;
  localparam logic [11:0] OFF_FLEX_MSK = 12'h140;
  localparam logic [11:0] OFF_CAP_BUF = 12'h200;
  // ==========================================================
  // field positions
  localparam int BIT_CAP_ENABLE = 2;
  localparam int BIT_ARMED = 4;
  localparam int BIT_TAB_ACCESS = 2;
  localparam int BIT_APM_WAKE_ENABLE = 0;
  localparam int BIT_LSC_EN = 4;
  localparam int BIT_LSC_ONLY = 5;
  localparam int BIT_LINK_CHANGED_FLAG = 0;
  localparam int BIT_PATTERN = 1;
  localparam int BIT_NO_MGMT = 11;
  localparam int BIT_APM_CFG_EN = 10;
  localparam int BIT_ADDR_VALID = 31;
  localparam int BIT_CAP_ARM = 4;
  // ==========================================================
  // reset values and sizes
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] FILT_KEEP = 16'hf7fc;
  localparam int FLEX_ENTRIES = 16;
  localparam int CAP_BYTES = 128;
  localparam int HDR_BYTES = 14;
  localparam int PAT_BYTES = 96;
  localparam int SYNC_FF = 6;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 25000000;
  localparam int RESEND_MS = 50;
  localparam int RESEND_CYCLES = (CLK_HZ / 1000) * RESEND_MS;
  // ==========================================================
  // carrier: per-frame filter verdicts from the receive classifier
  typedef struct packed {
    logic addr_pass;
    logic mgmt_pass;
    logic host_route;
    logic [15:0] hit;
  } hwc_verdict_t;
  typedef enum logic [1:0] {
    WK_IDLE,
    WK_REQ,
    WK_SEND,
    WK_WAIT_ACK
  } hwc_wake_st_t;
endpackage

// file: hwc_wake_ctrl.sv
// host wake controller: registers, wake detection, pin and message handshake
// Behaviour
// - capability enable opens wake function and filter register page; code gates only table access and flex writes with it, not wake detection
// - table access enable permits writes to flex value and mask tables
// - host clears table access, then sets armed to start detection
// - detected wake event drives wake request pin low
// - release message drops pin and sends wake source message
// - no new pin request until source message sent and acknowledged
// - held wake packet is never overwritten while wake active
// - in-band wake message resent after 50 ms without armed change
// - APM config enable first, then station address words copied in
// - writing third address word sets address valid bit
// - pattern match sets status flag and signals in-band wake
// - pattern wake works when either its enable or apm_wake_enable is set; disabled only by clearing both
// - link-only mode wakes on link change when both enables set
// - qualifying link change sets link flag and starts wake
// - link-only without enables: no link wake, filter bit reads zero
// - filter control bit 0 enables wake on link change
// - address filter plus enabled wake filter wakes, sets match flags
// - stored length readable, zero means none; write clears it
// - filter active only when enabled; management gate on matches
// - six 0xff then sixteen station addresses form a wake pattern
`timescale 1ns/1ps
module hwc_wake_ctrl #(
  parameter int RESEND_CYCLES = hwc_pkg::RESEND_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_clk_i,
  input wire logic rx_dv_i,
  input wire logic [7:0] rx_data_i,
  input wire hwc_pkg::hwc_verdict_t verdict_i,
  input wire logic link_up_i,
  input wire logic release_msg_i,
  input wire logic hub_ack_i,
  output logic [15:0] src_msg_o,
  output logic src_msg_valid_o,
  input wire logic src_msg_ready_i,
  output logic inband_wake_o,
  output logic wake_request_n_o
);
  // ==========================================================
  // state
  logic armed, cap_en, tab_access, apm_wake_enable, lsc_en, lsc_only, apm_cfg_en, cap_arm;
  logic [15:0] wake_filter_control_reg, wake_status_reg;
  logic [31:0] sta_low, sta_high;
  logic [31:0] flex_val [0:hwc_pkg::FLEX_ENTRIES-1];
  logic [31:0] flex_msk [0:hwc_pkg::FLEX_ENTRIES-1];
  logic [7:0] cap_mem [0:hwc_pkg::CAP_BYTES-1];
  logic [7:0] cap_len;
  logic cap_held;
  logic wr, rd_ok, armed_prev;
  logic [31:0] rd_val;
  logic [15:0] wake_filter_control_reg_rd;
  hwc_pkg::hwc_wake_st_t st;
  logic [20:0] resend_cnt;
  logic resend_run;
  // ==========================================================
  // input synchronisers
  logic clk_s1, clk_s2, clk_s3, dv_s1, dv_s2, link_s1, link_s2, link_s3;
  logic [7:0] dat_s1, dat_s2;
  always_ff @(posedge clk_i)
  begin
    clk_s1 <= rx_clk_i;
    clk_s2 <= clk_s1;
    clk_s3 <= clk_s2;
    dv_s1 <= rx_dv_i;
    dv_s2 <= dv_s1;
    dat_s1 <= rx_data_i;
    dat_s2 <= dat_s1;
    link_s1 <= link_up_i;
    link_s2 <= link_s1;
    link_s3 <= link_s2;
  end
  logic rx_edge, byte_v, in_frame, frame_end;
  assign rx_edge = clk_s2 & ~clk_s3;
  assign byte_v = rx_edge & dv_s2;
  assign frame_end = rx_edge & ~dv_s2 & in_frame;
  // ==========================================================
  // wishbone slave: one wait state, ack for one cycle
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & (&wb_sel_i);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end
  // ==========================================================
  // control registers
  logic flex_we, tab_open;
  assign tab_open = cap_en & ~armed;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      armed <= 1'b0;
      cap_en <= 1'b0;
      tab_access <= 1'b0;
      apm_wake_enable <= 1'b0;
      lsc_en <= 1'b0;
      lsc_only <= 1'b0;
      wake_filter_control_reg <= hwc_pkg::RST_WORD[15:0];
      apm_cfg_en <= 1'b0;
      cap_arm <= 1'b0;
    end
    else if (wr)
    begin
      unique case (wb_adr_i)
        hwc_pkg::OFF_PORT_CFG:
        begin
          armed <= wb_dat_i[hwc_pkg::BIT_ARMED];
          cap_en <= wb_dat_i[hwc_pkg::BIT_CAP_ENABLE];
        end
        hwc_pkg::OFF_RX_CTRL:
          if (tab_open)
            tab_access <= wb_dat_i[hwc_pkg::BIT_TAB_ACCESS];
        hwc_pkg::OFF_WAKE_CTRL:
        begin
          apm_wake_enable <= wb_dat_i[hwc_pkg::BIT_APM_WAKE_ENABLE];
          lsc_en <= wb_dat_i[hwc_pkg::BIT_LSC_EN];
          lsc_only <= wb_dat_i[hwc_pkg::BIT_LSC_ONLY];
        end
        hwc_pkg::OFF_WAKE_FILT:
          wake_filter_control_reg <= wb_dat_i[15:0];
        hwc_pkg::OFF_APM_CFG:
          apm_cfg_en <= wb_dat_i[hwc_pkg::BIT_APM_CFG_EN];
        hwc_pkg::OFF_CAP_CTRL:
          cap_arm <= wb_dat_i[hwc_pkg::BIT_CAP_ARM];
        default:
        begin
        end
      endcase
    end
  end
  // ==========================================================
  // station address copy
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sta_low <= hwc_pkg::RST_WORD;
      sta_high <= hwc_pkg::RST_WORD;
    end
    else if (wr && apm_cfg_en)
    begin
      if (wb_adr_i == hwc_pkg::OFF_STA_W0)
        sta_low[15:0] <= wb_dat_i[15:0];
      if (wb_adr_i == hwc_pkg::OFF_STA_W1)
        sta_low[31:16] <= wb_dat_i[15:0];
      if (wb_adr_i == hwc_pkg::OFF_STA_W2)
        sta_high <= {1'b1, 15'h0000, wb_dat_i[15:0]};
    end
  end
  // ==========================================================
  // flexible filter tables
  // writes need access enable
  assign flex_we = wr & tab_access & tab_open & (wb_adr_i[11:7] == 5'h02);
  always_ff @(posedge clk_i)
  begin
    if (flex_we && !wb_adr_i[6])
      flex_val[wb_adr_i[5:2]] <= wb_dat_i;
    if (flex_we && wb_adr_i[6])
      flex_msk[wb_adr_i[5:2]] <= wb_dat_i;
  end
  // ==========================================================
  // wake pattern scanner
  logic [10:0] byte_idx;
  logic [2:0] ff_run, pos;
  logic [6:0] pat_cnt;
  logic pat_hit;
  logic [7:0] sta_byte;
  always_comb
  begin
    unique case (pos)
      3'h0: sta_byte = sta_low[7:0];
      3'h1: sta_byte = sta_low[15:8];
      3'h2: sta_byte = sta_low[23:16];
      3'h3: sta_byte = sta_low[31:24];
      3'h4: sta_byte = sta_high[7:0];
      3'h5: sta_byte = sta_high[15:8];
      default: sta_byte = 8'h00;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i || frame_end)
    begin
      in_frame <= 1'b0;
      byte_idx <= 11'h000;
      ff_run <= 3'h0;
      pos <= 3'h0;
      pat_cnt <= 7'h00;
      pat_hit <= 1'b0;
    end
    else if (byte_v)
    begin
      in_frame <= 1'b1;
      if (byte_idx != 11'h7ff)
        byte_idx <= byte_idx + 11'h001;
      if (byte_idx >= 11'(hwc_pkg::HDR_BYTES) && !pat_hit)
      begin
        if (pat_cnt != 7'h00)
        begin
          if (dat_s2 == sta_byte)
          begin
            pat_cnt <= pat_cnt + 7'h01;
            pos <= (pos == 3'h5) ? 3'h0 : pos + 3'h1;
            if (pat_cnt == 7'(hwc_pkg::PAT_BYTES - 1))
              pat_hit <= 1'b1;
          end
          else
          begin
            pat_cnt <= 7'h00;
            pos <= 3'h0;
            ff_run <= (dat_s2 == 8'hff) ? 3'h1 : 3'h0;
          end
        end
        else if (dat_s2 == 8'hff)
        begin
          if (ff_run != 3'(hwc_pkg::SYNC_FF))
            ff_run <= ff_run + 3'h1;
        end
        else if (ff_run == 3'(hwc_pkg::SYNC_FF) && dat_s2 == sta_byte)
        begin
          pat_cnt <= 7'h01;
          pos <= 3'h1;
          ff_run <= 3'h0;
        end
        else
          ff_run <= 3'h0;
      end
    end
  end
  // ==========================================================
  // wake qualification
  logic pat_wake, mgmt_ok, pkt_wake, link_chg, link_wake, wake_evt;
  logic [15:0] hits;
  assign mgmt_ok = ~verdict_i.mgmt_pass | ~wake_filter_control_reg[hwc_pkg::BIT_NO_MGMT] | verdict_i.host_route;
  assign hits = verdict_i.hit & wake_filter_control_reg & hwc_pkg::FILT_KEEP;
  assign pat_wake = pat_hit & (apm_wake_enable | wake_filter_control_reg[hwc_pkg::BIT_PATTERN]);
  assign pkt_wake = frame_end & armed & verdict_i.addr_pass & mgmt_ok & (pat_wake | (|hits));
  assign link_chg = link_s2 ^ link_s3;
  assign link_wake = armed & link_chg & (lsc_only ? (apm_wake_enable & lsc_en) :
                     (wake_filter_control_reg[hwc_pkg::BIT_LINK_CHANGED_FLAG] | (apm_wake_enable & lsc_en)));
  assign wake_evt = pkt_wake | link_wake;
  assign wake_filter_control_reg_rd = {wake_filter_control_reg[15:1], wake_filter_control_reg[hwc_pkg::BIT_LINK_CHANGED_FLAG] & ~(lsc_only & ~(apm_wake_enable & lsc_en))};
  // ==========================================================
  // wake status, sticky, write one to clear, set wins
  logic [15:0] wus_set, wus_clr;
  always_comb
  begin
    wus_set = 16'h0000;
    if (link_wake)
      wus_set[hwc_pkg::BIT_LINK_CHANGED_FLAG] = 1'b1;
    if (pkt_wake)
    begin
      wus_set = wus_set | hits;
      wus_set[hwc_pkg::BIT_PATTERN] = pat_wake;
    end
  end
  assign wus_clr = (wr && wb_adr_i == hwc_pkg::OFF_WAKE_STAT) ? wb_dat_i[15:0] : 16'h0000;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wake_status_reg <= hwc_pkg::RST_WORD[15:0];
    else
      wake_status_reg <= (wake_status_reg & ~wus_clr) | wus_set;
  end
  // ==========================================================
  // wake packet capture
  logic cap_clr;
  assign cap_clr = wr & (wb_adr_i == hwc_pkg::OFF_CAP_CLR);
  always_ff @(posedge clk_i)
  begin
    if (byte_v && cap_arm && !cap_held && byte_idx < 11'(hwc_pkg::CAP_BYTES))
      cap_mem[byte_idx[6:0]] <= dat_s2;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cap_held <= 1'b0;
      cap_len <= 8'h00;
    end
    else if (pkt_wake && cap_arm && !cap_held)
    begin
      cap_held <= 1'b1;
      cap_len <= (byte_idx > 11'(hwc_pkg::CAP_BYTES)) ? 8'(hwc_pkg::CAP_BYTES) : byte_idx[7:0];
    end
    else if (cap_clr)
    begin
      cap_held <= 1'b0;
      cap_len <= 8'h00;
    end
  end
  // ==========================================================
  // pin and message handshake
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st <= hwc_pkg::WK_IDLE;
    else
    begin
      unique case (st)
        hwc_pkg::WK_IDLE:
          if (wake_evt)
            st <= hwc_pkg::WK_REQ;
        hwc_pkg::WK_REQ:
          if (release_msg_i)
            st <= hwc_pkg::WK_SEND;
        hwc_pkg::WK_SEND:
          if (src_msg_ready_i)
            st <= hwc_pkg::WK_WAIT_ACK;
        hwc_pkg::WK_WAIT_ACK:
          if (hub_ack_i)
            st <= hwc_pkg::WK_IDLE;
          else if (release_msg_i)
            st <= hwc_pkg::WK_SEND;
      endcase
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wake_request_n_o <= 1'b1;
    else
      wake_request_n_o <= ~((st == hwc_pkg::WK_IDLE && wake_evt) ||
                            (st == hwc_pkg::WK_REQ && !release_msg_i));
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      src_msg_o <= 16'h0000;
    else if (st == hwc_pkg::WK_REQ || st == hwc_pkg::WK_WAIT_ACK)
      src_msg_o <= wake_status_reg;
  end
  assign src_msg_valid_o = (st == hwc_pkg::WK_SEND);
  // ==========================================================
  // in-band wake message and resend timer
  logic resend_due;
  assign resend_due = resend_run && armed == armed_prev && resend_cnt == 21'(RESEND_CYCLES - 1);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      inband_wake_o <= 1'b0;
      resend_run <= 1'b0;
      resend_cnt <= 21'h000000;
      armed_prev <= 1'b0;
    end
    else
    begin
      armed_prev <= armed;
      inband_wake_o <= wake_evt | resend_due;
      if (armed != armed_prev)
      begin
        resend_run <= 1'b0;
        resend_cnt <= 21'h000000;
      end
      else if (wake_evt || resend_due)
      begin
        resend_run <= 1'b1;
        resend_cnt <= 21'h000000;
      end
      else if (resend_run)
        resend_cnt <= resend_cnt + 21'h000001;
    end
  end
  // ==========================================================
  // read mux
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (wb_adr_i[11:7] == 5'h02)
      rd_val = wb_adr_i[6] ? flex_msk[wb_adr_i[5:2]] : flex_val[wb_adr_i[5:2]];
    else if (wb_adr_i[11:8] == 4'h2 && wb_adr_i[7:2] < 6'h3f)
      rd_val = {16'h0000, cap_mem[{wb_adr_i[7:2], 1'b1}], cap_mem[{wb_adr_i[7:2], 1'b0}]};
    else
    begin
      unique case (wb_adr_i)
        hwc_pkg::OFF_PORT_CFG: rd_val = {27'h0, armed, 1'b0, cap_en, 2'h0};
        hwc_pkg::OFF_RX_CTRL: rd_val = {29'h0, tab_access, 2'h0};
        hwc_pkg::OFF_WAKE_CTRL: rd_val = {26'h0, lsc_only, lsc_en, 3'h0, apm_wake_enable};
        hwc_pkg::OFF_WAKE_FILT: rd_val = {16'h0, wake_filter_control_reg_rd};
        hwc_pkg::OFF_WAKE_STAT: rd_val = {16'h0, wake_status_reg};
        hwc_pkg::OFF_APM_CFG: rd_val = {21'h0, apm_cfg_en, 10'h0};
        hwc_pkg::OFF_STA_LOW: rd_val = sta_low;
        hwc_pkg::OFF_STA_HIGH: rd_val = sta_high;
        hwc_pkg::OFF_CAP_CTRL: rd_val = {27'h0, cap_arm, 4'h0};
        hwc_pkg::OFF_CAP_LEN: rd_val = {24'h0, cap_len};
        default: rd_ok = 1'b0;
      endcase
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
      wb_dat_o <= rd_ok ? rd_val : 32'h0000_0000;
  end
  // ==========================================================
  // checks
  property p_pin_on_event;
    @(posedge clk_i) disable iff (rst_i)
    (st == hwc_pkg::WK_IDLE && wake_evt) |=> !wake_request_n_o && (st == hwc_pkg::WK_REQ);
  endproperty
  a_pin_on_event: assert property (p_pin_on_event) else $error("pin not raised on wake");
  property p_release;
    @(posedge clk_i) disable iff (rst_i)
    (st == hwc_pkg::WK_REQ && release_msg_i) |=> wake_request_n_o && src_msg_valid_o;
  endproperty
  a_release: assert property (p_release) else $error("release not honoured");
  property p_no_reassert;
    @(posedge clk_i) disable iff (rst_i)
    (st == hwc_pkg::WK_WAIT_ACK && !hub_ack_i) |=> wake_request_n_o;
  endproperty
  a_no_reassert: assert property (p_no_reassert) else $error("pin before ack");
  property p_link_changed_flag_zero;
    @(posedge clk_i) disable iff (rst_i)
    (lsc_only && !(apm_wake_enable && lsc_en)) |-> !wake_filter_control_reg_rd[hwc_pkg::BIT_LINK_CHANGED_FLAG] && !link_wake;
  endproperty
  a_link_changed_flag_zero: assert property (p_link_changed_flag_zero) else $error("link bit not masked");
  property p_addr_valid;
    @(posedge clk_i) disable iff (rst_i)
    (wr && apm_cfg_en && wb_adr_i == hwc_pkg::OFF_STA_W2) |=> sta_high[hwc_pkg::BIT_ADDR_VALID];
  endproperty
  a_addr_valid: assert property (p_addr_valid) else $error("address valid not set");
  property p_held;
    @(posedge clk_i) disable iff (rst_i)
    (cap_held && !cap_clr) |=> $stable(cap_len) && cap_held;
  endproperty
  a_held: assert property (p_held) else $error("held packet changed");
  property p_resend;
    @(posedge clk_i) disable iff (rst_i)
    (resend_due && armed == armed_prev) |=> inband_wake_o;
  endproperty
  a_resend: assert property (p_resend) else $error("no resend");
  property p_pattern_flag;
    @(posedge clk_i) disable iff (rst_i)
    (pkt_wake && pat_wake) |=> wake_status_reg[hwc_pkg::BIT_PATTERN] ##0 inband_wake_o;
  endproperty
  a_pattern_flag: assert property (p_pattern_flag) else $error("pattern flag missing");
endmodule

// file: testbench.sv
// self-checking bench for the host wake controller
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, rx_clk_i = 1'b0, rx_dv_i = 1'b0, link_up_i = 1'b0;
  logic [7:0] rx_data_i = 8'h00;
  hwc_pkg::hwc_verdict_t verdict_i = '0;
  logic release_msg_i, hub_ack_i, src_msg_ready_i, src_msg_valid_o, inband_wake_o, wake_request_n_o;
  logic [15:0] src_msg_o, last_msg;
  int n_fail = 0, checked = 0, cycles = 0, n_inb = 0, n0;
  logic [7:0] sta [6] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc};
  // ==========================================================
  // design and hub
  hwc_wake_ctrl #(.RESEND_CYCLES(200)) hwc_wake_ctrl_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_clk_i(rx_clk_i), .rx_dv_i(rx_dv_i), .rx_data_i(rx_data_i), .verdict_i(verdict_i),
    .link_up_i(link_up_i), .release_msg_i(release_msg_i), .hub_ack_i(hub_ack_i),
    .src_msg_o(src_msg_o), .src_msg_valid_o(src_msg_valid_o), .src_msg_ready_i(src_msg_ready_i),
    .inband_wake_o(inband_wake_o), .wake_request_n_o(wake_request_n_o));
  hwc_hub_model #(.DLY(3)) hwc_hub_model_i (.clk_i(clk_i), .rst_i(rst_i),
    .wake_request_n_i(wake_request_n_o), .src_msg_valid_i(src_msg_valid_o),
    .src_msg_i(src_msg_o), .release_msg_o(release_msg_i), .hub_ack_o(hub_ack_i),
    .src_msg_ready_o(src_msg_ready_i), .last_msg_o(last_msg));
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end
  // ==========================================================
  // bus, link and wait helpers
  task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    `CHK(rd, exp)
  endtask
  task automatic rx_byte(input logic dv, input logic [7:0] b);
    @(posedge clk_i);
    rx_clk_i <= 1'b0;
    rx_dv_i <= dv;
    rx_data_i <= b;
    repeat (4) @(posedge clk_i);
    rx_clk_i <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic frame(input logic [7:0] s, input logic pat, input logic [15:0] hit);
    verdict_i <= '{addr_pass: 1'b1, mgmt_pass: 1'b0, host_route: 1'b0, hit: hit};
    for (int i = 0; i < 14; i++) rx_byte(1'b1, i < 6 ? sta[i] : (i < 12 ? s : 8'h00));
    for (int i = 0; i < 102; i++) rx_byte(1'b1, !pat ? 8'h00 : (i < 6 ? 8'hff : sta[(i - 6) % 6]));
    rx_byte(1'b0, 8'h5a);
  endtask
  task automatic wait_pin(input logic exp);
    for (int i = 0; i < 40 && wake_request_n_o !== exp; i++) @(posedge clk_i);
  endtask
  task automatic hs_done;
    for (int i = 0; i < 60 && hub_ack_i !== 1'b1; i++) @(posedge clk_i);
    @(posedge clk_i);
  endtask
  task automatic rearm;
    wb(1'b1, hwc_pkg::OFF_PORT_CFG, 32'h4);
    wb(1'b1, hwc_pkg::OFF_PORT_CFG, 32'h14);
    wb(1'b1, hwc_pkg::OFF_WAKE_STAT, 32'hffff);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_setup;
    `CHK(wake_request_n_o, 1'b1)
    rchk(hwc_pkg::OFF_PORT_CFG, 32'h0);
    rchk(12'hffc, 32'h0);
    wb(1'b1, hwc_pkg::OFF_PORT_CFG, 32'h4);
    wb(1'b1, hwc_pkg::OFF_RX_CTRL, 32'h4);
    wb(1'b1, hwc_pkg::OFF_FLEX_VAL, 32'hcafe0001);
    rchk(hwc_pkg::OFF_FLEX_VAL, 32'hcafe0001);
    wb(1'b1, hwc_pkg::OFF_RX_CTRL, 32'h0);
    wb(1'b1, hwc_pkg::OFF_FLEX_VAL, 32'h1234);
    rchk(hwc_pkg::OFF_FLEX_VAL, 32'hcafe0001);
    wb(1'b1, hwc_pkg::OFF_APM_CFG, 32'h400);
    wb(1'b1, hwc_pkg::OFF_STA_W0, 32'h3412);
    wb(1'b1, hwc_pkg::OFF_STA_W1, 32'h7856);
    wb(1'b1, hwc_pkg::OFF_STA_W2, 32'hbc9a);
    rchk(hwc_pkg::OFF_STA_LOW, 32'h78563412);
    rchk(hwc_pkg::OFF_STA_HIGH, 32'h8000bc9a);
    wb(1'b1, hwc_pkg::OFF_WAKE_CTRL, 32'h1);
    wb(1'b1, hwc_pkg::OFF_PORT_CFG, 32'h14);
    $display("test setup done");
  endtask
  task automatic t_link;
    wb(1'b1, hwc_pkg::OFF_WAKE_CTRL, 32'h21);
    wb(1'b1, hwc_pkg::OFF_WAKE_FILT, 32'h1);
    rchk(hwc_pkg::OFF_WAKE_FILT, 32'h0);
    link_up_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    `CHK(wake_request_n_o, 1'b1)
    wb(1'b1, hwc_pkg::OFF_WAKE_CTRL, 32'h31);
    link_up_i <= 1'b0;
    wait_pin(1'b0);
    `CHK(wake_request_n_o, 1'b0)
    rchk(hwc_pkg::OFF_WAKE_STAT, 32'h1);
    hs_done();
    `CHK(last_msg, 16'h0001)
    `CHK(wake_request_n_o, 1'b1)
    $display("test link done");
  endtask
  task automatic t_filter;
    rearm();
    wb(1'b1, hwc_pkg::OFF_WAKE_CTRL, 32'h1);
    wb(1'b1, hwc_pkg::OFF_WAKE_FILT, 32'h4);
    frame(8'h01, 1'b0, 16'h000c);
    wait_pin(1'b0);
    `CHK(wake_request_n_o, 1'b0)
    rchk(hwc_pkg::OFF_WAKE_STAT, 32'h4);
    hs_done();
    `CHK(last_msg, 16'h0004)
    wb(1'b1, hwc_pkg::OFF_WAKE_FILT, 32'h1);
    link_up_i <= 1'b1;
    wait_pin(1'b0);
    `CHK(wake_request_n_o, 1'b0)
    hs_done();
    $display("test filter done");
  endtask
  task automatic t_pattern;
    rearm();
    wb(1'b1, hwc_pkg::OFF_WAKE_FILT, 32'h0);
    wb(1'b1, hwc_pkg::OFF_CAP_CLR, 32'h1);
    wb(1'b1, hwc_pkg::OFF_CAP_CTRL, 32'h10);
    n0 = n_inb;
    frame(8'h01, 1'b1, 16'h0);
    wait_pin(1'b0);
    `CHK(wake_request_n_o, 1'b0)
    repeat (420) @(posedge clk_i);
    `CHK(n_inb - n0, 3)
    `CHK(last_msg, 16'h0002)
    rchk(hwc_pkg::OFF_WAKE_STAT, 32'h2);
    rchk(hwc_pkg::OFF_CAP_LEN, 32'h74);
    rchk(hwc_pkg::OFF_CAP_BUF + 12'h00c, 32'h0101);
    frame(8'h55, 1'b1, 16'h0);
    wait_pin(1'b0);
    hs_done();
    rchk(hwc_pkg::OFF_CAP_BUF + 12'h00c, 32'h0101);
    wb(1'b1, hwc_pkg::OFF_PORT_CFG, 32'h4);
    repeat (2) @(posedge clk_i);
    n0 = n_inb;
    repeat (450) @(posedge clk_i);
    `CHK(n_inb - n0, 0)
    wb(1'b1, hwc_pkg::OFF_CAP_CLR, 32'h1);
    rchk(hwc_pkg::OFF_CAP_LEN, 32'h0);
    $display("test pattern done");
  endtask
  task automatic t_reset;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK(wake_request_n_o, 1'b1)
    wb(1'b1, hwc_pkg::OFF_PORT_CFG, 32'h0);
    rchk(hwc_pkg::OFF_WAKE_STAT, 32'h0);
    rchk(hwc_pkg::OFF_CAP_LEN, 32'h0);
    $display("test reset done");
  endtask
  // ==========================================================
  // run control
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (inband_wake_o === 1'b1)
      n_inb <= n_inb + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      conclude();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_setup();
    t_link();
    t_filter();
    t_pattern();
    t_reset();
    conclude();
  end
endmodule
